/* logic/bp_compare.sv */
`timescale 1ns/1ps
module bp_compare (
  input wire logic [trace_debug_pkg::WordW-1:0] value,
  input wire logic [trace_debug_pkg::WordW-1:0] refValue,
  input wire logic [trace_debug_pkg::WordW-1:0] mask,
  output logic hit
);
  // A set mask bit enables its position; cleared bits always match.
  assign hit = ~|((value ^ refValue) & mask);
endmodule // bp_compare

/* logic/debug_serial_link.sv */
`timescale 1ns/1ps
module debug_serial_link (
  input wire logic serialClk,
  input wire logic rst,
  input wire logic serialIn,
  input wire logic [trace_debug_pkg::WordW-1:0] respWord,
  output logic serialOut,
  output logic [trace_debug_pkg::FrameW-1:0] frameWord,
  output logic frameToggle
);
  logic [trace_debug_pkg::BitCntW-1:0] bitCnt_q;
  logic [trace_debug_pkg::FrameW-1:0] shiftIn_q;
  logic [trace_debug_pkg::WordW-1:0] shiftOut_q;

  // ************************************************************
  // Receive shifter, sampled on the rising serial clock.
  // ************************************************************
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      bitCnt_q <= '0;
      shiftIn_q <= '0;
    end else begin
      shiftIn_q <= {shiftIn_q[trace_debug_pkg::FrameW-2:0], serialIn};
      if (bitCnt_q == trace_debug_pkg::FrameLast) begin
        bitCnt_q <= '0;
      end else begin
        bitCnt_q <= bitCnt_q + 1'b1;
      end
    end
  end

  // The frame is held here until the next frame ends, which gives the
  // system side a whole frame time to take it after the toggle moves.
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      frameWord <= '0;
      frameToggle <= 1'b0;
    end else if (bitCnt_q == trace_debug_pkg::FrameLast) begin
      frameWord <= {shiftIn_q[trace_debug_pkg::FrameW-2:0], serialIn};
      frameToggle <= ~frameToggle;
    end
  end

  // ************************************************************
  // Transmit shifter: the previous read answer goes out during the
  // next frame. The answer word is stable long before that frame.
  // ************************************************************
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      shiftOut_q <= '0;
    end else if (bitCnt_q == '0) begin
      shiftOut_q <= {respWord[trace_debug_pkg::WordW-2:0], 1'b0};
    end else begin
      shiftOut_q <= {shiftOut_q[trace_debug_pkg::WordW-2:0], 1'b0};
    end
  end

  assign serialOut = (bitCnt_q == '0) ?
    respWord[trace_debug_pkg::WordW-1] :
    shiftOut_q[trace_debug_pkg::WordW-1];
endmodule // debug_serial_link

/* logic/trace_breakpoint_debug.sv */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Nine 32-bit breakpoint value and mask registers.
// - Serial channel and supervisor software reach registers.
// - Address, data, PC conditions; single or dual level.
// - Trigger halts core or raises debug interrupt.
// - Critical interrupts still pass while emulating.
// - Drive status bus, trace data, trace clock.
// - Trace outputs update every processor clock.
// - All-status flag is AND of status bits.
// - Halted state shows status value 1111.
// - Serial channel and all-status flag always present.
module trace_breakpoint_debug (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [trace_debug_pkg::IdxW-1:0] regAddr,
  input wire logic [trace_debug_pkg::WordW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic supervisorMode,
  output logic [trace_debug_pkg::WordW-1:0] regRdData,
  input wire logic debug_serial_clock,
  input wire logic debugSerialIn,
  output logic debug_serial_out,
  input wire logic [trace_debug_pkg::WordW-1:0] busAddr,
  input wire logic [trace_debug_pkg::WordW-1:0] busData,
  input wire logic busValid,
  input wire logic [trace_debug_pkg::WordW-1:0] pcValue,
  input wire logic pcValid,
  input wire logic [trace_debug_pkg::NibW-1:0] coreStatus,
  input wire logic [trace_debug_pkg::NibW-1:0] coreTraceData,
  input wire logic criticalIrqReq,
  input wire logic emulationExit,
  output logic coreHalt,
  output logic debugIrqReq,
  output logic criticalIrqPass,
  output logic [trace_debug_pkg::NibW-1:0] processor_status_bus,
  output logic [trace_debug_pkg::NibW-1:0] debug_trace_data_bus,
  output logic trace_clock_out,
  output logic all_status_high_flag
);
  localparam int unsigned W = trace_debug_pkg::WordW;
  localparam int unsigned NP = trace_debug_pkg::NumPc;
  localparam int unsigned CW = trace_debug_pkg::CondW;

  function automatic logic condMet(input logic [CW-1:0] sel,
                                   input logic [CW-1:0] hits);
    condMet = (|sel) && ((sel & hits) == sel);
  endfunction

  // ************************************************************
  // Breakpoint register storage.
  // ************************************************************
  logic [W-1:0] addrVal_q;
  logic [W-1:0] addrMask_q;
  logic [W-1:0] dataVal_q;
  logic [W-1:0] dataMask_q;
  logic [W-1:0] pcVal_q [NP];
  logic [W-1:0] pcMask_q;
  logic [W-1:0] trigCtrl_q;
  logic halted_q;
  logic emulating_q;
  logic trigSeen_q;
  trace_debug_pkg::trig_state_t trigState_q;

  // ************************************************************
  // Serial channel in its own clock domain.
  // ************************************************************
  logic [trace_debug_pkg::FrameW-1:0] frameWord;
  logic frameToggle;
  logic [W-1:0] respWord_q;
  logic tglSync1_q;
  logic tglSync2_q;
  logic tglSeen_q;
  logic serWr;
  logic serRd;
  logic [trace_debug_pkg::IdxW-1:0] serIdx;
  logic [W-1:0] serData;

  debug_serial_link serialLink (
    .serialClk(debug_serial_clock),
    .rst(rst),
    .serialIn(debugSerialIn),
    .respWord(respWord_q),
    .serialOut(debug_serial_out),
    .frameWord(frameWord),
    .frameToggle(frameToggle)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tglSync1_q <= 1'b0;
      tglSync2_q <= 1'b0;
      tglSeen_q <= 1'b0;
    end else begin
      tglSync1_q <= frameToggle;
      tglSync2_q <= tglSync1_q;
      tglSeen_q <= tglSync2_q;
    end
  end

  // The frame word is only read once its toggle has been seen twice
  // synchronised, so it has long stopped moving.
  assign serIdx = frameWord[W +: trace_debug_pkg::IdxW];
  assign serData = frameWord[W-1:0];
  assign serRd = (tglSync2_q != tglSeen_q) &&
                 frameWord[trace_debug_pkg::FrameW-1];
  assign serWr = (tglSync2_q != tglSeen_q) &&
                 !frameWord[trace_debug_pkg::FrameW-1];

  // ************************************************************
  // Access arbitration. Software writes need supervisor mode; a
  // serial write in the same cycle wins because the tool is master.
  // ************************************************************
  logic cpuWr;
  logic anyWr;
  logic [trace_debug_pkg::IdxW-1:0] wrIdx;
  logic [W-1:0] wrData;
  logic goReq;

  assign cpuWr = regWr && supervisorMode;
  assign anyWr = serWr || cpuWr;
  assign wrIdx = serWr ? serIdx : regAddr;
  assign wrData = serWr ? serData : regWrData;
  assign goReq = anyWr && (wrIdx == trace_debug_pkg::IdxTrigCtrl) &&
                 wrData[trace_debug_pkg::TcGo];

  function automatic logic [W-1:0] readReg(
      input logic [trace_debug_pkg::IdxW-1:0] idx,
      input logic [W-1:0] av, input logic [W-1:0] am,
      input logic [W-1:0] dv, input logic [W-1:0] dm,
      input logic [W-1:0] p0, input logic [W-1:0] p1,
      input logic [W-1:0] p2, input logic [W-1:0] p3,
      input logic [W-1:0] pm, input logic [W-1:0] tc,
      input logic [W-1:0] st);
    if (idx == trace_debug_pkg::IdxAddrVal) begin
      readReg = av;
    end else if (idx == trace_debug_pkg::IdxAddrMask) begin
      readReg = am;
    end else if (idx == trace_debug_pkg::IdxDataVal) begin
      readReg = dv;
    end else if (idx == trace_debug_pkg::IdxDataMask) begin
      readReg = dm;
    end else if (idx == trace_debug_pkg::IdxPcVal0) begin
      readReg = p0;
    end else if (idx == trace_debug_pkg::IdxPcVal0 + 4'h1) begin
      readReg = p1;
    end else if (idx == trace_debug_pkg::IdxPcVal0 + 4'h2) begin
      readReg = p2;
    end else if (idx == trace_debug_pkg::IdxPcVal0 + 4'h3) begin
      readReg = p3;
    end else if (idx == trace_debug_pkg::IdxPcMask) begin
      readReg = pm;
    end else if (idx == trace_debug_pkg::IdxTrigCtrl) begin
      readReg = tc;
    end else if (idx == trace_debug_pkg::IdxStatus) begin
      readReg = st;
    end else begin
      readReg = trace_debug_pkg::WordZero;
    end
  endfunction

  logic [W-1:0] statusWord;
  always_comb begin
    statusWord = trace_debug_pkg::WordZero;
    statusWord[trace_debug_pkg::StHalted] = halted_q;
    statusWord[trace_debug_pkg::StArmed] =
      (trigState_q == trace_debug_pkg::TrigArmed);
    statusWord[trace_debug_pkg::StTrigSeen] = trigSeen_q;
    statusWord[trace_debug_pkg::StEmulating] = emulating_q;
  end

  // ************************************************************
  // Register writes.
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrVal_q <= '0;
      addrMask_q <= '0;
      dataVal_q <= '0;
      dataMask_q <= '0;
      pcMask_q <= '0;
      trigCtrl_q <= '0;
    end else if (anyWr) begin
      if (wrIdx == trace_debug_pkg::IdxAddrVal) begin
        addrVal_q <= wrData;
      end else if (wrIdx == trace_debug_pkg::IdxAddrMask) begin
        addrMask_q <= wrData;
      end else if (wrIdx == trace_debug_pkg::IdxDataVal) begin
        dataVal_q <= wrData;
      end else if (wrIdx == trace_debug_pkg::IdxDataMask) begin
        dataMask_q <= wrData;
      end else if (wrIdx == trace_debug_pkg::IdxPcMask) begin
        pcMask_q <= wrData;
      end else if (wrIdx == trace_debug_pkg::IdxTrigCtrl) begin
        trigCtrl_q <= wrData & trace_debug_pkg::TrigCtrlWrMask;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : gPcReg
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pcVal_q[gi] <= '0;
        end else if (anyWr && (wrIdx ==
            trace_debug_pkg::IdxPcVal0 + 4'(gi))) begin
          pcVal_q[gi] <= wrData;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Register reads: software data one cycle after the strobe; the
  // serial answer waits in respWord_q for the next frame.
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd && supervisorMode) begin
      regRdData <= readReg(regAddr, addrVal_q, addrMask_q, dataVal_q,
        dataMask_q, pcVal_q[0], pcVal_q[1], pcVal_q[2], pcVal_q[3],
        pcMask_q, trigCtrl_q, statusWord);
    end else begin
      regRdData <= '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      respWord_q <= '0;
    end else if (serRd) begin
      respWord_q <= readReg(serIdx, addrVal_q, addrMask_q, dataVal_q,
        dataMask_q, pcVal_q[0], pcVal_q[1], pcVal_q[2], pcVal_q[3],
        pcMask_q, trigCtrl_q, statusWord);
    end
  end

  // ************************************************************
  // Comparators and trigger sequencing.
  // ************************************************************
  logic addrHit;
  logic dataHit;
  logic [NP-1:0] pcHitVec;
  logic [CW-1:0] hits;
  logic l1Met;
  logic l2Met;
  logic fire;

  bp_compare addrCmp (
    .value(busAddr),
    .refValue(addrVal_q),
    .mask(addrMask_q),
    .hit(addrHit)
  );

  bp_compare dataCmp (
    .value(busData),
    .refValue(dataVal_q),
    .mask(dataMask_q),
    .hit(dataHit)
  );

  generate
    for (gi = 0; gi < NP; gi++) begin : gPcCmp
      bp_compare pcCmp (
        .value(pcValue),
        .refValue(pcVal_q[gi]),
        .mask(pcMask_q),
        .hit(pcHitVec[gi])
      );
    end
  endgenerate

  assign hits = {pcValid && (|pcHitVec), busValid && dataHit,
                 busValid && addrHit};
  assign l1Met = condMet(trigCtrl_q[trace_debug_pkg::TcL1Lo +: CW],
                         hits);
  assign l2Met = condMet(trigCtrl_q[trace_debug_pkg::TcL2Lo +: CW],
                         hits);

  // A fired trigger stays spent until software or the serial tool rewrites the control
  // register, so one breakpoint gives exactly one action.
  always_comb begin
    fire = 1'b0;
    case (trigState_q)
      trace_debug_pkg::TrigIdle: begin
        fire = trigCtrl_q[trace_debug_pkg::TcEnable] &&
               !trigCtrl_q[trace_debug_pkg::TcDual] && l1Met;
      end
      trace_debug_pkg::TrigArmed: begin
        fire = l2Met;
      end
      default: begin
        fire = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigState_q <= trace_debug_pkg::TrigIdle;
    end else if (anyWr && (wrIdx == trace_debug_pkg::IdxTrigCtrl)) begin
      trigState_q <= trace_debug_pkg::TrigIdle;
    end else begin
      case (trigState_q)
        trace_debug_pkg::TrigIdle: begin
          if (fire) begin
            trigState_q <= trace_debug_pkg::TrigDone;
          end else if (trigCtrl_q[trace_debug_pkg::TcEnable] &&
                       trigCtrl_q[trace_debug_pkg::TcDual] && l1Met) begin
            trigState_q <= trace_debug_pkg::TrigArmed;
          end
        end
        trace_debug_pkg::TrigArmed: begin
          if (fire) begin
            trigState_q <= trace_debug_pkg::TrigDone;
          end
        end
        default: begin
          trigState_q <= trace_debug_pkg::TrigDone;
        end
      endcase
    end
  end

  // ************************************************************
  // Trigger action. A new trigger wins over a clear in one cycle.
  // ************************************************************
  logic haltFire;
  logic irqFire;

  assign irqFire = fire && trigCtrl_q[trace_debug_pkg::TcIrqAction];
  assign haltFire = fire && !trigCtrl_q[trace_debug_pkg::TcIrqAction];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      halted_q <= 1'b0;
    end else if (haltFire) begin
      halted_q <= 1'b1;
    end else if (goReq) begin
      halted_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      emulating_q <= 1'b0;
      debugIrqReq <= 1'b0;
    end else begin
      debugIrqReq <= irqFire;
      if (irqFire) begin
        emulating_q <= 1'b1;
      end else if (emulationExit) begin
        emulating_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trigSeen_q <= 1'b0;
    end else if (fire) begin
      trigSeen_q <= 1'b1;
    end else if (anyWr && (wrIdx == trace_debug_pkg::IdxTrigCtrl)) begin
      trigSeen_q <= 1'b0;
    end
  end

  assign coreHalt = halted_q;
  // A halted core runs nothing, but an emulating one keeps serving
  // critical interrupts so the system stays alive under debug.
  assign criticalIrqPass = criticalIrqReq && !halted_q;

  // ************************************************************
  // Trace port, updated on every processor clock.
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      processor_status_bus <= '0;
      debug_trace_data_bus <= '0;
      all_status_high_flag <= 1'b0;
    end else begin
      if (halted_q) begin
        processor_status_bus <= trace_debug_pkg::StatusHalted;
        all_status_high_flag <= 1'b1;
      end else begin
        processor_status_bus <= coreStatus;
        all_status_high_flag <= &coreStatus;
      end
      debug_trace_data_bus <= coreTraceData;
    end
  end

  // The tool samples the trace buses against this copy of the clock.
  assign trace_clock_out = sys_clk;
endmodule // trace_breakpoint_debug

/* logic/trace_debug_pkg.sv */
package trace_debug_pkg;
  localparam int unsigned WordW = 32;
  localparam int unsigned IdxW = 4;
  localparam int unsigned NibW = 4;
  localparam int unsigned NumPc = 4;
  // Serial frame: read flag, register index, data word, MSB first.
  localparam int unsigned FrameW = 1 + IdxW + WordW;
  localparam int unsigned BitCntW = 6;
  localparam logic [BitCntW-1:0] FrameLast = 6'h24;
  // Register indices on the software port and on the serial channel.
  localparam logic [IdxW-1:0] IdxAddrVal = 4'h0;
  localparam logic [IdxW-1:0] IdxAddrMask = 4'h1;
  localparam logic [IdxW-1:0] IdxDataVal = 4'h2;
  localparam logic [IdxW-1:0] IdxDataMask = 4'h3;
  localparam logic [IdxW-1:0] IdxPcVal0 = 4'h4;
  localparam logic [IdxW-1:0] IdxPcMask = 4'h8;
  localparam logic [IdxW-1:0] IdxTrigCtrl = 4'h9;
  localparam logic [IdxW-1:0] IdxStatus = 4'ha;
  // Trigger control fields.
  localparam int unsigned TcEnable = 0;
  localparam int unsigned TcDual = 1;
  localparam int unsigned TcIrqAction = 2;
  localparam int unsigned TcL1Lo = 4;
  localparam int unsigned TcL2Lo = 8;
  localparam int unsigned TcGo = 12;
  localparam int unsigned CondW = 3;
  localparam logic [WordW-1:0] TrigCtrlWrMask = 32'h0000_0777;
  // Status fields.
  localparam int unsigned StHalted = 0;
  localparam int unsigned StArmed = 1;
  localparam int unsigned StTrigSeen = 2;
  localparam int unsigned StEmulating = 3;
  localparam logic [NibW-1:0] StatusHalted = 4'hf;
  localparam logic [WordW-1:0] WordZero = 32'h0000_0000;
  typedef enum logic [1:0] {
    TrigIdle = 2'b00,
    TrigArmed = 2'b01,
    TrigDone = 2'b10
  } trig_state_t;
endpackage

/* sim/debug_tool_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// External debug tool on the serial channel.
// ****************************************************************
module debug_tool_model (
  output logic serialClk,
  output logic serialData,
  input wire logic serialReturn
);
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
  end
  // The clock only runs inside a frame; between frames the data line
  // shows the inverse of its last bit so a stale level is never trusted.
  task automatic frame(input logic rdFlag, input logic [3:0] idx,
      input logic [31:0] data, output logic [31:0] answer);
    logic [36:0] bits;
    bits = {rdFlag, idx, data};
    answer = 32'h0;
    for (int k = 0; k < 37; k++) begin
      serialData = bits[36-k];
      #40;
      if (k < 32) answer[31-k] = serialReturn;
      serialClk = 1'b1;
      #40;
      serialClk = 1'b0;
    end
    serialData = ~bits[0];
    #700;
  endtask
endmodule // debug_tool_model

/* sim/trace_breakpoint_debug_bench.sv */
`timescale 1ns/1ps
module trace_breakpoint_debug_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic supervisorMode = 1'b1;
  logic [31:0] busAddr = 32'h0;
  logic [31:0] busData = 32'h0;
  logic [31:0] pcValue = 32'h0;
  logic busValid = 1'b0;
  logic pcValid = 1'b0;
  logic [3:0] coreStatus = 4'h0;
  logic [3:0] coreTraceData = 4'h0;
  logic criticalIrqReq = 1'b0;
  logic emulationExit = 1'b0;
  logic serialClk, serialIn, serialOut, coreHalt, debugIrqReq;
  logic criticalIrqPass, traceClk, allFlag;
  logic [3:0] statusBus, traceBus;
  logic [31:0] regRdData, seed, got, a, d, p;
  logic [31:0] shadow [0:15];
  int errors = 0;
  int num_checks = 0;
  int irqCount = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (debugIrqReq === 1'b1) irqCount++;
  debug_tool_model tool (.serialClk(serialClk), .serialData(serialIn),
    .serialReturn(serialOut));
  trace_breakpoint_debug uut (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .supervisorMode(supervisorMode), .regRdData(regRdData),
    .debug_serial_clock(serialClk), .debugSerialIn(serialIn),
    .debug_serial_out(serialOut), .busAddr(busAddr), .busData(busData),
    .busValid(busValid), .pcValue(pcValue), .pcValid(pcValid),
    .coreStatus(coreStatus), .coreTraceData(coreTraceData),
    .criticalIrqReq(criticalIrqReq), .emulationExit(emulationExit),
    .coreHalt(coreHalt), .debugIrqReq(debugIrqReq),
    .criticalIrqPass(criticalIrqPass), .processor_status_bus(statusBus),
    .debug_trace_data_bus(traceBus), .trace_clock_out(traceClk),
    .all_status_high_flag(allFlag));
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] expect_reg(input logic [3:0] i,
      input logic [31:0] w);
    if (i == trace_debug_pkg::IdxTrigCtrl) begin
      return w & trace_debug_pkg::TrigCtrlWrMask;
    end
    return (i > trace_debug_pkg::IdxStatus) ? 32'h0 : w;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] w);
    @(posedge sys_clk);
    regAddr <= i;
    regWrData <= w;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, output logic [31:0] r);
    @(posedge sys_clk);
    regAddr <= i;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 r = regRdData;
  endtask
  task automatic hit(input logic [31:0] ad, input logic [31:0] da,
      input logic [31:0] pc, input logic bv, input logic pv);
    @(posedge sys_clk);
    busAddr <= ad;
    busData <= da;
    pcValue <= pc;
    busValid <= bv;
    pcValid <= pv;
    @(posedge sys_clk);
    busValid <= 1'b0;
    pcValid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    #500_000;
    errors++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h0249907b;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(lfsr(seed));
      shadow[i] = seed;
      if (i != 10) wr(i[3:0], seed);
    end
    for (int i = 0; i < 16; i++) begin
      if (i != 10) rd(i[3:0], got);
      if (i != 10) chk(got, expect_reg(i[3:0], shadow[i]));
    end
    supervisorMode <= 1'b0;
    wr(trace_debug_pkg::IdxAddrVal, ~shadow[0]);
    rd(trace_debug_pkg::IdxAddrVal, got);
    chk(got, 32'h0);
    supervisorMode <= 1'b1;
    rd(trace_debug_pkg::IdxAddrVal, got);
    chk(got, shadow[0]);
    #13;
    seed = lfsr(seed);
    tool.frame(1'b0, trace_debug_pkg::IdxDataVal, seed, got);
    rd(trace_debug_pkg::IdxDataVal, got);
    chk(got, seed);
    wr(4'h5, ~seed);
    tool.frame(1'b1, 4'h5, 32'h0, got);
    tool.frame(1'b1, 4'h0, 32'h0, got);
    chk(got, ~seed);
    a = lfsr(seed);
    wr(trace_debug_pkg::IdxAddrVal, a);
    wr(trace_debug_pkg::IdxAddrMask, 32'hffff_ff00);
    wr(trace_debug_pkg::IdxTrigCtrl, 32'h0000_0011);
    hit(a ^ 32'h0001_0000, seed, seed, 1'b1, 1'b0);
    chk(coreHalt, 1'b0);
    hit(a ^ 32'h0000_00c3, seed, seed, 1'b1, 1'b0);
    chk(coreHalt, 1'b1);
    chk(statusBus, 4'hf);
    chk(allFlag, 1'b1);
    rd(trace_debug_pkg::IdxStatus, got);
    chk(got[trace_debug_pkg::StHalted], 1'b1);
    criticalIrqReq <= 1'b1;
    @(posedge sys_clk) #1;
    chk(criticalIrqPass, 1'b0);
    wr(trace_debug_pkg::IdxTrigCtrl, 32'h0000_1000);
    repeat (2) @(posedge sys_clk);
    #1 chk(coreHalt, 1'b0);
    p = lfsr(a);
    d = lfsr(p);
    wr(4'h6, p);
    wr(trace_debug_pkg::IdxPcMask, 32'hffff_ffff);
    wr(trace_debug_pkg::IdxDataVal, d);
    wr(trace_debug_pkg::IdxDataMask, 32'hffff_ffff);
    wr(trace_debug_pkg::IdxTrigCtrl, 32'h0000_0247);
    hit(a, d, p ^ 32'h1, 1'b1, 1'b1);
    chk(irqCount, 0);
    hit(a, ~d, p, 1'b0, 1'b1);
    chk(irqCount, 0);
    hit(a, d, ~p, 1'b1, 1'b0);
    chk(irqCount, 1);
    chk(coreHalt, 1'b0);
    chk(criticalIrqPass, 1'b1);
    hit(a, d, p, 1'b1, 1'b1);
    chk(irqCount, 1);
    emulationExit <= 1'b1;
    criticalIrqReq <= 1'b0;
    @(posedge sys_clk);
    emulationExit <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      coreStatus <= (i == 0) ? 4'hf : seed[3:0];
      coreTraceData <= seed[7:4];
      @(posedge sys_clk) #1;
      chk(statusBus, (i == 0) ? 4'hf : seed[3:0]);
      chk(traceBus, seed[7:4]);
      chk(allFlag, (i == 0) || (&seed[3:0]));
      chk(traceClk, sys_clk);
    end
    tally_and_finish();
  end
endmodule // trace_breakpoint_debug_bench

/* sim/trace_breakpoint_debug_monitor.sv */
`timescale 1ns/1ps
// ****************************************************************
// Checker on the trace, trigger and register read ports.
// ****************************************************************
module trace_breakpoint_debug_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [trace_debug_pkg::IdxW-1:0] regAddr,
  input wire logic [trace_debug_pkg::WordW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic supervisorMode,
  input wire logic [trace_debug_pkg::WordW-1:0] regRdData,
  input wire logic busValid,
  input wire logic pcValid,
  input wire logic [trace_debug_pkg::NibW-1:0] coreStatus,
  input wire logic [trace_debug_pkg::NibW-1:0] coreTraceData,
  input wire logic criticalIrqReq,
  input wire logic coreHalt,
  input wire logic debugIrqReq,
  input wire logic criticalIrqPass,
  input wire logic [trace_debug_pkg::NibW-1:0] processor_status_bus,
  input wire logic [trace_debug_pkg::NibW-1:0] debug_trace_data_bus,
  input wire logic trace_clock_out,
  input wire logic all_status_high_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_allFlag;
    all_status_high_flag == (&processor_status_bus);
  endproperty
  a_allFlag: assert property (p_allFlag)
    else $error("all-status flag wrong");
  property p_haltShows;
    coreHalt |=> processor_status_bus == trace_debug_pkg::StatusHalted;
  endproperty
  a_haltShows: assert property (p_haltShows)
    else $error("halt not on status bus");
  property p_statusFollows;
    !coreHalt |=> processor_status_bus == $past(coreStatus);
  endproperty
  a_statusFollows: assert property (p_statusFollows)
    else $error("status bus not following");
  property p_dataFollows;
    1'b1 |=> debug_trace_data_bus == $past(coreTraceData);
  endproperty
  a_dataFollows: assert property (p_dataFollows)
    else $error("trace data not following");
  property p_irqPulse;
    debugIrqReq |=> !debugIrqReq;
  endproperty
  a_irqPulse: assert property (p_irqPulse)
    else $error("debug interrupt too long");
  property p_critPass;
    criticalIrqPass == (criticalIrqReq && !coreHalt);
  endproperty
  a_critPass: assert property (p_critPass)
    else $error("critical interrupt gating");
  property p_rdIdle;
    !(regRd && supervisorMode) |=> regRdData == trace_debug_pkg::WordZero;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data not zero");
  // The trace clock mirrors the system clock, so it is high at each fall.
  property p_traceClk;
    @(negedge sys_clk) trace_clock_out;
  endproperty
  a_traceClk: assert property (p_traceClk)
    else $error("trace clock wrong");
  property p_haltCause;
    $rose(coreHalt) |-> $past(busValid || pcValid);
  endproperty
  a_haltCause: assert property (p_haltCause)
    else $error("halt without compare");
  property p_haltHold;
    coreHalt && !(regWr && supervisorMode && regWrData[trace_debug_pkg::TcGo]
      && regAddr == trace_debug_pkg::IdxTrigCtrl) |=> coreHalt;
  endproperty
  a_haltHold: assert property (p_haltHold)
    else $error("halt released without go");
  c_halt: cover property (coreHalt ##1 all_status_high_flag);
  c_irq: cover property (debugIrqReq);
  c_read: cover property (regRd && supervisorMode ##1 regRdData != 32'h0);
endmodule // trace_breakpoint_debug_monitor

bind trace_breakpoint_debug trace_breakpoint_debug_monitor mon (.*);
